/* pkg/pief_pkg.sv */
// Constants shared by the peripheral interrupt enable and flag logic
package pief_pkg;

  // Avalon-MM slave geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // Byte addresses of the registers
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_CORE_CTRL = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h10;

  // Source positions, shared by enable, flag, status and mask registers
  localparam int BIT_CONV_DONE = 6;
  localparam int BIT_CAPCMP = 5;
  localparam int BIT_COMPARATOR = 3;
  localparam int BIT_PERIOD_MATCH = 1;
  localparam int BIT_TIMER_A_OVF = 0;

  // Positions inside the core interrupt control register
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_MASTER_EN = 6;

  // Implemented positions for the full and the reduced variant
  localparam logic [REG_W-1:0] IMPL_FULL = 8'h6b;
  localparam logic [REG_W-1:0] IMPL_REDUCED = 8'h09;
  localparam logic [REG_W-1:0] CORE_CTRL_IMPL = 8'hc0;

  // Reset values
  localparam logic [REG_W-1:0] RST_ENABLE = 8'h00;
  localparam logic [REG_W-1:0] RST_FLAGS = 8'h00;
  localparam logic [REG_W-1:0] RST_CORE_CTRL = 8'h00;
  localparam logic [REG_W-1:0] RST_STATUS = 8'h00;
  localparam logic [REG_W-1:0] RST_MASK = 8'h00;

  // Width of the second timer count and period
  localparam int TIMER_B_W = 8;

  // Operating mode of the capture/compare unit
  typedef enum logic [1:0] {
    CC_OFF = 2'h0,
    CC_CAPTURE = 2'h1,
    CC_COMPARE = 2'h2,
    CC_PWM = 2'h3
  } pief_ccmode_t;

endpackage : pief_pkg

/* verilog/pief_ctrl.sv */
// Peripheral interrupt enable, request flags and core request gating
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module pief_ctrl #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rstn,

  // Avalon-MM slave
  input wire logic [pief_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pief_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [pief_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,

  // Peripheral event sources, all on sys_clk
  input wire logic conv_done_evt,
  input wire logic capture_evt,
  input wire logic compare_evt,
  input wire pief_pkg::pief_ccmode_t capcmp_mode,
  input wire logic comparator_out,
  input wire logic [pief_pkg::TIMER_B_W-1:0] timer_b_count,
  input wire logic [pief_pkg::TIMER_B_W-1:0] timer_b_period,
  input wire logic timer_a_ovf_evt,

  // Request toward the core and summary interrupt
  output logic periph_irq,
  output logic irq
);
  import pief_pkg::*;

  // Implemented positions of the enable and flag registers
  localparam logic [REG_W-1:0] IMPL = REDUCED_VARIANT ? IMPL_REDUCED : IMPL_FULL;

  // Register file
  logic [REG_W-1:0] periph_enable_reg;
  logic [REG_W-1:0] periph_flag_reg;
  logic [REG_W-1:0] core_irq_ctrl_reg;
  logic [REG_W-1:0] irq_status_reg;
  logic [REG_W-1:0] irq_mask_reg;

  // Bus handshake
  logic waitrequest_reg;
  logic [DATA_W-1:0] readdata_reg;
  logic bus_ack;
  logic wr_ack;
  logic rd_ack;
  logic low_lane;

  // Event detection
  logic comparator_prev_reg;
  logic comparator_seen_reg;
  logic period_match_prev_reg;
  logic period_match_now;
  logic [REG_W-1:0] event_vec;

  // Outputs
  logic periph_irq_reg;
  logic irq_reg;
  logic periph_irq_next;
  logic irq_next;
  logic global_irq_en;
  logic periph_master_en;

  // Next values
  logic [REG_W-1:0] periph_enable_next;
  logic [REG_W-1:0] periph_flag_next;
  logic [REG_W-1:0] core_irq_ctrl_next;
  logic [REG_W-1:0] irq_status_next;
  logic [REG_W-1:0] irq_mask_next;
  logic [DATA_W-1:0] readdata_next;

  // Register strobes, decoded once from the answered access
  logic wr_enable;
  logic wr_flags;
  logic wr_core_ctrl;
  logic wr_mask;
  logic rd_status;

  // Qualified events, one per source
  logic conv_evt;
  logic capcmp_evt;
  logic comparator_evt;
  logic match_evt;
  logic ovf_evt;

  // Enabled flags that are pending toward the core
  logic [REG_W-1:0] pending_vec;

  // Address match, used by every register decode
  function automatic logic addr_is(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    addr_is = (addr == off);
  endfunction : addr_is

  // Zero-extend a register onto the data bus
  function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] value);
    widen = {{(DATA_W-REG_W){1'b0}}, value};
  endfunction : widen

  // Write strobe of one register: completed write, low byte lane, matching offset
  function automatic logic wr_hit(
    input logic ack,
    input logic lane,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    wr_hit = ack & lane & addr_is(addr, off);
  endfunction : wr_hit

  // Bus handshake: one wait state, then waitrequest low for one cycle
  assign bus_ack = (avs_read | avs_write) & waitrequest_reg;
  // A write lands only at the edge where the master sees waitrequest low
  assign wr_ack = avs_write & ~waitrequest_reg;
  // Reads are captured one edge early so the data stand while waitrequest is low
  assign rd_ack = bus_ack & avs_read;
  assign low_lane = avs_byteenable[0];

  // Per-register strobes
  assign wr_enable = wr_hit(wr_ack, low_lane, avs_address, OFF_ENABLE);
  assign wr_flags = wr_hit(wr_ack, low_lane, avs_address, OFF_FLAGS);
  assign wr_core_ctrl = wr_hit(wr_ack, low_lane, avs_address, OFF_CORE_CTRL);
  assign wr_mask = wr_hit(wr_ack, low_lane, avs_address, OFF_IRQ_MASK);
  assign rd_status = rd_ack & addr_is(avs_address, OFF_IRQ_STATUS);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= ~bus_ack;
    end
  end

  // Event detection
  assign period_match_now = (timer_b_count == timer_b_period);

  // Comparator edge needs a primed previous value to avoid a false change after reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      comparator_prev_reg <= 1'b0;
      comparator_seen_reg <= 1'b0;
    end else begin
      comparator_prev_reg <= comparator_out;
      comparator_seen_reg <= 1'b1;
    end
  end

  // A match that lasts several cycles counts once
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      period_match_prev_reg <= 1'b1;
    end else begin
      period_match_prev_reg <= period_match_now;
    end
  end

  assign conv_evt = conv_done_evt;
  // Pulse-width and off modes raise no capture/compare event
  assign capcmp_evt = (capture_evt & (capcmp_mode == CC_CAPTURE)) |
                      (compare_evt & (capcmp_mode == CC_COMPARE));
  assign comparator_evt = comparator_seen_reg &
                          (comparator_out != comparator_prev_reg);
  assign match_evt = period_match_now & ~period_match_prev_reg;
  assign ovf_evt = timer_a_ovf_evt;

  // Positions of a variant without the source never see an event
  always_comb begin
    event_vec = '0;
    event_vec[BIT_CONV_DONE] = conv_evt;
    event_vec[BIT_CAPCMP] = capcmp_evt;
    event_vec[BIT_COMPARATOR] = comparator_evt;
    event_vec[BIT_PERIOD_MATCH] = match_evt;
    event_vec[BIT_TIMER_A_OVF] = ovf_evt;
    event_vec = event_vec & IMPL;
  end

  // Enable register
  always_comb begin
    periph_enable_next = periph_enable_reg;
    if (wr_enable) begin
      periph_enable_next = avs_writedata[REG_W-1:0] & IMPL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      periph_enable_reg <= RST_ENABLE;
    end else begin
      periph_enable_reg <= periph_enable_next;
    end
  end

  // Flag register: software write, then events OR in on top
  // Writing one sets a flag from software, writing zero clears it
  always_comb begin
    periph_flag_next = periph_flag_reg;
    if (wr_flags) begin
      periph_flag_next = avs_writedata[REG_W-1:0] & IMPL;
    end
    periph_flag_next = periph_flag_next | event_vec;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      periph_flag_reg <= RST_FLAGS;
    end else begin
      periph_flag_reg <= periph_flag_next;
    end
  end

  // Core interrupt control: global and peripheral master enables
  always_comb begin
    core_irq_ctrl_next = core_irq_ctrl_reg;
    if (wr_core_ctrl) begin
      core_irq_ctrl_next = avs_writedata[REG_W-1:0] & CORE_CTRL_IMPL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      core_irq_ctrl_reg <= RST_CORE_CTRL;
    end else begin
      core_irq_ctrl_reg <= core_irq_ctrl_next;
    end
  end

  assign global_irq_en = core_irq_ctrl_reg[BIT_GLOBAL_EN];
  assign periph_master_en = core_irq_ctrl_reg[BIT_PERIPH_MASTER_EN];

  // Sticky status for the summary interrupt: cleared by reading it
  // The clear falls on the edge the read data are captured, so no event is lost
  always_comb begin
    irq_status_next = irq_status_reg;
    if (rd_status) begin
      irq_status_next = '0;
    end
    irq_status_next = irq_status_next | event_vec;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_status_reg <= RST_STATUS;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_comb begin
    irq_mask_next = irq_mask_reg;
    if (wr_mask) begin
      irq_mask_next = avs_writedata[REG_W-1:0] & IMPL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_mask_reg <= RST_MASK;
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Read data, captured in the cycle waitrequest drops
  always_comb begin
    readdata_next = readdata_reg;
    if (rd_ack) begin
      if (addr_is(avs_address, OFF_ENABLE)) begin
        readdata_next = widen(periph_enable_reg & IMPL);
      end else if (addr_is(avs_address, OFF_FLAGS)) begin
        readdata_next = widen(periph_flag_reg & IMPL);
      end else if (addr_is(avs_address, OFF_CORE_CTRL)) begin
        readdata_next = widen(core_irq_ctrl_reg);
      end else if (addr_is(avs_address, OFF_IRQ_STATUS)) begin
        readdata_next = widen(irq_status_reg);
      end else if (addr_is(avs_address, OFF_IRQ_MASK)) begin
        readdata_next = widen(irq_mask_reg);
      end else begin
        readdata_next = '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      readdata_reg <= '0;
    end else begin
      readdata_reg <= readdata_next;
    end
  end

  // Request toward the core and summary interrupt
  assign pending_vec = periph_flag_reg & periph_enable_reg;

  always_comb begin
    periph_irq_next = |pending_vec;
    periph_irq_next = periph_irq_next & periph_master_en;
    periph_irq_next = periph_irq_next & global_irq_en;
  end

  assign irq_next = |(irq_status_reg & irq_mask_reg);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      periph_irq_reg <= 1'b0;
    end else begin
      periph_irq_reg <= periph_irq_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign avs_waitrequest = waitrequest_reg;
  assign avs_readdata = readdata_reg;
  assign periph_irq = periph_irq_reg;
  assign irq = irq_reg;

endmodule : pief_ctrl

/* verification/pief_ctrl_properties.sv */
// Port-level properties of the peripheral interrupt block
`timescale 1ns/10ps
module pief_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [pief_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pief_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic periph_irq,
  input wire logic irq
);
  import pief_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic mapped;
  assign mapped = avs_address inside {OFF_ENABLE, OFF_FLAGS, OFF_CORE_CTRL, OFF_IRQ_STATUS,
    OFF_IRQ_MASK};
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_no_idle_ans: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_rd_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_rd_unused: assert property (!avs_waitrequest && avs_read && avs_address != OFF_CORE_CTRL
    |-> !avs_readdata[7] && !avs_readdata[4] && !avs_readdata[2])
    else $error("unimplemented bit read as one");
  a_unmapped_zero: assert property (!avs_waitrequest && avs_read && !mapped
    |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn
    |=> avs_waitrequest && !periph_irq && !irq)
    else $error("outputs not quiet in reset");
  a_pirq_hold: assert property ($fell(periph_irq)
    |-> $past(!avs_waitrequest && avs_write, 2) || $past(!rstn))
    else $error("peripheral request dropped without a write");
  a_irq_hold: assert property ($fell(irq) |-> $past(!avs_waitrequest && avs_read) ||
    $past(!avs_waitrequest && avs_write, 2) || $past(!rstn))
    else $error("interrupt dropped without an access");
  c_read: cover property (!avs_waitrequest && avs_read);
  c_pirq: cover property ($rose(periph_irq));
  c_irq_clr: cover property ($fell(irq));
endmodule : pief_props

/* verification/pief_src_model.sv */
// Behavioural event sources facing the interrupt block
`timescale 1ns/10ps
module pief_src_model #(
  parameter logic [7:0] PERIOD = 8'h3c
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [5:0] fire,
  output logic conv_done_evt,
  output logic capture_evt,
  output logic compare_evt,
  output logic comparator_out,
  output logic [7:0] timer_b_count,
  output logic [7:0] timer_b_period,
  output logic timer_a_ovf_evt
);
  assign timer_b_period = PERIOD;
  // One-cycle pulses; the count meets the period only when asked
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {conv_done_evt, capture_evt, compare_evt, timer_a_ovf_evt} <= 4'h0;
      comparator_out <= 1'b0;
      timer_b_count <= 8'h00;
    end else begin
      {conv_done_evt, capture_evt, compare_evt, timer_a_ovf_evt} <= {fire[5:3], fire[0]};
      comparator_out <= comparator_out ^ fire[2];
      timer_b_count <= fire[1] ? PERIOD : ~PERIOD;
    end
  end
endmodule : pief_src_model

/* verification/tb_pief_ctrl.sv */
// Self-checking bench for the peripheral interrupt block
`timescale 1ns/10ps
module tb_pief_ctrl;
  import pief_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic conv_done_evt, capture_evt, compare_evt, comparator_out, timer_a_ovf_evt;
  logic [TIMER_B_W-1:0] timer_b_count, timer_b_period;
  pief_ccmode_t capcmp_mode = CC_OFF;
  logic [5:0] fire = 6'h00;
  logic periph_irq, irq;
  logic [31:0] rd;
  logic [31:0] red_rd;
  logic [DATA_W-1:0] red_readdata;
  logic [7:0] en, ex;
  logic [5:0] m;
  int err_total = 0;
  int n_checks = 0;
  localparam bit PIN_PIRQ = 1'b0;
  localparam bit PIN_IRQ = 1'b1;
  always #20 sys_clk = ~sys_clk;
  pief_src_model u_src (.sys_clk(sys_clk), .rstn(rstn), .fire(fire),
    .conv_done_evt(conv_done_evt), .capture_evt(capture_evt), .compare_evt(compare_evt),
    .comparator_out(comparator_out), .timer_b_count(timer_b_count),
    .timer_b_period(timer_b_period), .timer_a_ovf_evt(timer_a_ovf_evt));
  pief_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_done_evt(conv_done_evt),
    .capture_evt(capture_evt), .compare_evt(compare_evt), .capcmp_mode(capcmp_mode),
    .comparator_out(comparator_out), .timer_b_count(timer_b_count),
    .timer_b_period(timer_b_period), .timer_a_ovf_evt(timer_a_ovf_evt),
    .periph_irq(periph_irq), .irq(irq));
  // Reduced variant on the same stimulus; its read data are compared
  pief_ctrl #(.REDUCED_VARIANT(1'b1)) dut_red (.sys_clk(sys_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(red_readdata), .avs_waitrequest(), .conv_done_evt(conv_done_evt),
    .capture_evt(capture_evt), .compare_evt(compare_evt), .capcmp_mode(capcmp_mode),
    .comparator_out(comparator_out), .timer_b_count(timer_b_count),
    .timer_b_period(timer_b_period), .timer_a_ovf_evt(timer_a_ovf_evt),
    .periph_irq(), .irq());
  function automatic logic [7:0] exp_flags(input logic [5:0] f, input pief_ccmode_t md);
    exp_flags = {1'b0, f[5], (f[4] && md == CC_CAPTURE) || (f[3] && md == CC_COMPARE),
      1'b0, f[2], 1'b0, f[1], f[0]};
  endfunction : exp_flags
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input bit wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    red_rd = red_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e});
    chk(red_rd, {24'h000000, (a == OFF_CORE_CTRL) ? e : (e & IMPL_REDUCED)});
  endtask : rd_chk
  task automatic pin_chk(input bit sel_irq, input logic e);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, (sel_irq ? irq : periph_irq)}, {31'h0, e});
  endtask : pin_chk
  task automatic pulse(input logic [5:0] f);
    fire <= f;
    @(posedge sys_clk);
    fire <= 6'h00;
    repeat (4) @(posedge sys_clk);
  endtask : pulse
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end
  initial begin
    logic [ADDR_W-1:0] offs [5] = '{OFF_ENABLE, OFF_FLAGS, OFF_CORE_CTRL, OFF_IRQ_STATUS,
      OFF_IRQ_MASK};
    logic [7:0] impl [5] = '{IMPL_FULL, IMPL_FULL, CORE_CTRL_IMPL, 8'h00, IMPL_FULL};
    void'($urandom(5335));
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++) rd_chk(offs[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      if (i != 3) bus(1'b1, offs[i], 8'hff);
      if (i != 3) rd_chk(offs[i], impl[i]);
    end
    avs_byteenable <= 4'h0;
    bus(1'b1, OFF_ENABLE, 8'h00);
    avs_byteenable <= 4'hf;
    rd_chk(OFF_ENABLE, IMPL_FULL);
    bus(1'b1, 5'h14, 8'hff);
    rd_chk(5'h14, 8'h00);
    $display("test registers done");
    bus(1'b0, OFF_IRQ_STATUS, 8'h00);
    pin_chk(PIN_PIRQ, 1'b1);
    bus(1'b1, OFF_CORE_CTRL, 8'h80);
    pin_chk(PIN_PIRQ, 1'b0);
    bus(1'b1, OFF_CORE_CTRL, 8'h40);
    pin_chk(PIN_PIRQ, 1'b0);
    bus(1'b1, OFF_CORE_CTRL, 8'hc0);
    pin_chk(PIN_PIRQ, 1'b1);
    fork
      bus(1'b1, OFF_FLAGS, 8'h00);
      begin
        fire <= 6'h01;
        @(posedge sys_clk);
        fire <= 6'h00;
      end
    join
    rd_chk(OFF_FLAGS, 8'h01);
    repeat (20) @(posedge sys_clk);
    rd_chk(OFF_FLAGS, 8'h01);
    pin_chk(PIN_PIRQ, 1'b1);
    bus(1'b1, OFF_FLAGS, 8'h00);
    pin_chk(PIN_PIRQ, 1'b0);
    $display("test gating done");
    bus(1'b1, OFF_ENABLE, 8'h00);
    bus(1'b1, OFF_CORE_CTRL, 8'h00);
    for (int md = 0; md < 4; md++) begin
      for (int k = 0; k < 6; k++) begin
        capcmp_mode <= pief_ccmode_t'(md);
        pulse(6'h01 << k);
        rd_chk(OFF_FLAGS, exp_flags(6'h01 << k, pief_ccmode_t'(md)));
        pin_chk(PIN_PIRQ, 1'b0);
        bus(1'b1, OFF_FLAGS, 8'h00);
      end
    end
    $display("test sources done");
    bus(1'b1, OFF_IRQ_MASK, 8'h08);
    bus(1'b0, OFF_IRQ_STATUS, 8'h00);
    pin_chk(PIN_IRQ, 1'b0);
    pulse(6'h01);
    pin_chk(PIN_IRQ, 1'b0);
    pulse(6'h04);
    pin_chk(PIN_IRQ, 1'b1);
    rd_chk(OFF_IRQ_STATUS, 8'h09);
    pin_chk(PIN_IRQ, 1'b0);
    rd_chk(OFF_IRQ_STATUS, 8'h00);
    $display("test status done");
    bus(1'b1, OFF_CORE_CTRL, 8'hc0);
    for (int n = 0; n < 16; n++) begin
      en = 8'($urandom) & IMPL_FULL;
      m = 6'($urandom);
      bus(1'b1, OFF_FLAGS, 8'h00);
      bus(1'b1, OFF_ENABLE, en);
      capcmp_mode <= pief_ccmode_t'($urandom_range(3));
      @(posedge sys_clk);
      ex = exp_flags(m, capcmp_mode);
      pulse(m);
      rd_chk(OFF_FLAGS, ex);
      pin_chk(PIN_PIRQ, |(ex & en));
    end
    $display("test random done");
    print_verdict();
  end
endmodule : tb_pief_ctrl
bind pief_ctrl pief_props u_props (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .periph_irq(periph_irq), .irq(irq));
